/* src/multi_port_io_map.vh */
`ifndef MULTI_PORT_IO_MAP_VH
`define MULTI_PORT_IO_MAP_VH

// ****************************************
// port widths
// ****************************************
`define SIX_W    6
`define THREE_W  3
`define OCT_W    8

// ****************************************
// reset values
// ****************************************
`define SIX_DIR_RST     6'h00
`define SIX_LATCH_RST   6'h00
`define THREE_DIR_RST   3'h0
`define THREE_LATCH_RST 3'h7
`define OCT_DIR_RST     8'h00
`define OCT_LATCH_RST   8'h00
`define OCT_OD_RST      8'h00
`define AIN_DIS_RST     1'b1

// ****************************************
// port select codes on the cpu access
// ****************************************
`define SEL_SIX    3'h0
`define SEL_THREE  3'h1
`define SEL_MOTOR  3'h2
`define SEL_SERIAL 3'h3
`define SEL_ANALOG 3'h4

// ****************************************
// register select within a port
// ****************************************
`define REG_LATCH  2'h0
`define REG_DIR    2'h1
`define REG_OD     2'h2

// ****************************************
// fill value for undefined read bits of the three-bit port
// ****************************************
`define THREE_FILL 5'h00

`endif

/* src/pin_slice.v */
`timescale 1ns/1ps
// ****************************************
// one port: pin synchroniser and pad drive
// ****************************************
module pin_slice #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         resetn,
  // port state
  input  wire [W-1:0] dir,
  input  wire [W-1:0] latch,
  input  wire [W-1:0] open_drain,
  input  wire [W-1:0] force_hiz,
  // pads
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out,
  output wire [W-1:0] pin_oe,
  // synchronised pin level
  output reg  [W-1:0] pin_sync
);

  reg [W-1:0] pin_meta;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // open drain pulls low only; a latch one releases the pin
      assign pin_out[i] = latch[i];
      assign pin_oe[i]  = dir[i] & ~force_hiz[i] & ~(open_drain[i] & latch[i]);
    end
  endgenerate

endmodule // pin_slice

/* src/multi_port_io_block.v */
// Functional notes
// RQ1 - outputs come from held latches; inputs are live pin levels, never latched
// RQ2 - pin data is sampled in state s1 of the read cycle
// RQ3 - latches and pins update in state s2 of the write cycle
// RQ4 - read-modify-write reads the latch; other reads return the pin level
// RQ5 - six-bit port resets to input mode with latch zero
// RQ6 - three-bit latch resets to ones; software keeps ones for inputs
// RQ7 - three-bit port reads give undefined upper bits seven to three
// RQ8 - in stop mode the stop release pin floats regardless of output hold
// RQ9 - falling edge of own output on interrupt pin sets the interrupt latch
// RQ10 - motor port resets to input mode with latch zero
// RQ11 - motor port has per-bit open drain select, reset to tri-state
// RQ12 - open drain ports: read-modify-write reads latch, others read pin
// RQ13 - software sets motor latch bits to one for motor drive output
// RQ14 - serial port resets to input, latch zero, tri-state
// RQ15 - analog port resets direction and latch zero, input disable set (analog_input_disable is an input here and the block does not reset it)
// RQ16 - digital input on analog port needs direction zero and latch one
// RQ17 - analog input needs direction and latch zero before conversion starts
// RQ18 - analog port bits with latch zero read as zero
// RQ19 - software keeps analog pins inputs and avoids writes while converting
// RQ20 - analog read-modify-write reads pins and rewrites all eight latches
// RQ21 - a pin drives its latch only while its direction bit is one
`timescale 1ns/1ps
`include "multi_port_io_map.vh"

module multi_port_io_block (
  // clock and reset
  input  wire                   clk,
  input  wire                   resetn,
  // cpu state phases
  input  wire                   state_s1,
  input  wire                   state_s2,
  // cpu access
  input  wire                   rd_req,
  input  wire                   wr_req,
  input  wire                   rmw,
  input  wire [2:0]             port_sel,
  input  wire [1:0]             reg_sel,
  input  wire [7:0]             wr_data,
  output reg  [7:0]             rd_data,
  // mode controls
  input  wire                   stop_mode,
  input  wire                   stop_output_hold,
  input  wire                   analog_input_disable,
  // six-bit port pads
  input  wire [`SIX_W-1:0]      six_bit_port_in,
  output wire [`SIX_W-1:0]      six_bit_port_out,
  output wire [`SIX_W-1:0]      six_bit_port_oe,
  // three-bit port pads
  input  wire [`THREE_W-1:0]    three_bit_port_in,
  output wire [`THREE_W-1:0]    three_bit_port_out,
  output wire [`THREE_W-1:0]    three_bit_port_oe,
  output reg  [`THREE_W-1:0]    ext_int_self_set,
  // motor port pads
  input  wire [`OCT_W-1:0]      motor_port_in,
  output wire [`OCT_W-1:0]      motor_port_out,
  output wire [`OCT_W-1:0]      motor_port_oe,
  // serial port pads
  input  wire [`OCT_W-1:0]      serial_port_in,
  output wire [`OCT_W-1:0]      serial_port_out,
  output wire [`OCT_W-1:0]      serial_port_oe,
  // analog port pads
  input  wire [`OCT_W-1:0]      analog_port_in,
  output wire [`OCT_W-1:0]      analog_port_out,
  output wire [`OCT_W-1:0]      analog_port_oe
);

  // ****************************************
  // latches and controls
  // ****************************************
  reg  [`SIX_W-1:0]   six_bit_port_direction;
  reg  [`SIX_W-1:0]   six_bit_port_latch;
  reg  [`THREE_W-1:0] three_bit_port_latch;
  reg  [`OCT_W-1:0]   motor_port_direction;
  reg  [`OCT_W-1:0]   motor_port_latch;
  reg  [`OCT_W-1:0]   motor_port_open_drain;
  reg  [`OCT_W-1:0]   serial_port_direction;
  reg  [`OCT_W-1:0]   serial_port_latch;
  reg  [`OCT_W-1:0]   serial_port_open_drain;
  reg  [`OCT_W-1:0]   analog_port_direction;
  reg  [`OCT_W-1:0]   analog_port_latch;
  reg  [`THREE_W-1:0] three_out_prev;

  // the three-bit port has no direction register: it drives as
  // quasi open drain, so a latch one leaves the pin free for input
  wire [`THREE_W-1:0] three_dir = ~three_bit_port_latch;
  // so a zero in the latch drives low and the pin is never driven high

  // ****************************************
  // synchronised pin levels and pad drive
  // ****************************************
  wire [`SIX_W-1:0]   six_pin;
  wire [`THREE_W-1:0] three_pin;
  wire [`OCT_W-1:0]   motor_pin;
  wire [`OCT_W-1:0]   serial_pin;
  wire [`OCT_W-1:0]   analog_pin;
  wire [`THREE_W-1:0] three_hiz;

  // pin levels pass two flops before any read; a pin that moves in the
  // two cycles before a read may still show its old level
  // stop release pin floats in stop whatever the hold bit says
  assign three_hiz = {{(`THREE_W-1){stop_mode & ~stop_output_hold}}, stop_mode}; // see RQ8

  // six-bit port: plain push-pull, no open drain select
  pin_slice #(.W(`SIX_W)) u_six (
    .clk        (clk),
    .resetn     (resetn),
    .dir        (six_bit_port_direction),
    .latch      (six_bit_port_latch),
    .open_drain ({`SIX_W{1'b0}}),
    .force_hiz  ({`SIX_W{1'b0}}),
    .pin_in     (six_bit_port_in),
    .pin_out    (six_bit_port_out),
    .pin_oe     (six_bit_port_oe),
    .pin_sync   (six_pin)
  ); // see RQ21

  // three-bit port: the latch decides the drive, and stop mode can force the pins to float
  pin_slice #(.W(`THREE_W)) u_three (
    .clk        (clk),
    .resetn     (resetn),
    .dir        (three_dir),
    .latch      (three_bit_port_latch),
    .open_drain ({`THREE_W{1'b0}}),
    .force_hiz  (three_hiz),
    .pin_in     (three_bit_port_in),
    .pin_out    (three_bit_port_out),
    .pin_oe     (three_bit_port_oe),
    .pin_sync   (three_pin)
  );

  // motor port: open drain releases the pin on a latch one
  pin_slice #(.W(`OCT_W)) u_motor (
    .clk        (clk),
    .resetn     (resetn),
    .dir        (motor_port_direction),
    .latch      (motor_port_latch),
    .open_drain (motor_port_open_drain),
    .force_hiz  ({`OCT_W{1'b0}}),
    .pin_in     (motor_port_in),
    .pin_out    (motor_port_out),
    .pin_oe     (motor_port_oe),
    .pin_sync   (motor_pin)
  ); // see RQ11

  // serial port: same drive scheme as the motor port
  pin_slice #(.W(`OCT_W)) u_serial (
    .clk        (clk),
    .resetn     (resetn),
    .dir        (serial_port_direction),
    .latch      (serial_port_latch),
    .open_drain (serial_port_open_drain),
    .force_hiz  ({`OCT_W{1'b0}}),
    .pin_in     (serial_port_in),
    .pin_out    (serial_port_out),
    .pin_oe     (serial_port_oe),
    .pin_sync   (serial_pin)
  );

  // analog port drive ignores the converter; keeping analog pins as
  // inputs is left to software
  pin_slice #(.W(`OCT_W)) u_analog (
    .clk        (clk),
    .resetn     (resetn),
    .dir        (analog_port_direction),
    .latch      (analog_port_latch),
    .open_drain ({`OCT_W{1'b0}}),
    .force_hiz  ({`OCT_W{1'b0}}),
    .pin_in     (analog_port_in),
    .pin_out    (analog_port_out),
    .pin_oe     (analog_port_oe),
    .pin_sync   (analog_pin)
  );

  // ****************************************
  // read data selection
  // ****************************************
  // the gate also keeps a floating analog pin from reading as one
  // analog inputs read low while disabled or while the latch is zero
  wire [`OCT_W-1:0] analog_in_gated =
    analog_pin & analog_port_latch & {`OCT_W{~analog_input_disable}}; // see RQ15 see RQ18

  // rd_data is registered so the cpu value stays put until the next
  // read capture, whatever the pins do meanwhile; a read outside s1
  // leaves the last captured value in place
  reg [7:0] next_rd_data;

  always @* begin
    next_rd_data = 8'h00;
    if (reg_sel == `REG_DIR) begin
      if (port_sel == `SEL_SIX) begin
        next_rd_data = {2'h0, six_bit_port_direction};
      end else if (port_sel == `SEL_MOTOR) begin
        next_rd_data = motor_port_direction;
      end else if (port_sel == `SEL_SERIAL) begin
        next_rd_data = serial_port_direction;
      end else if (port_sel == `SEL_ANALOG) begin
        next_rd_data = analog_port_direction;
      end
    end else if (reg_sel == `REG_OD) begin
      if (port_sel == `SEL_MOTOR) begin
        next_rd_data = motor_port_open_drain;
      end else if (port_sel == `SEL_SERIAL) begin
        next_rd_data = serial_port_open_drain;
      end
    end else if (port_sel == `SEL_SIX) begin
      next_rd_data = {2'h0, rmw ? six_bit_port_latch : six_pin}; // see RQ4 see RQ1
    end else if (port_sel == `SEL_THREE) begin
      // undefined upper bits read as zero so a compare never meets x
      next_rd_data = {`THREE_FILL, rmw ? three_bit_port_latch : three_pin}; // see RQ7 see RQ4
    end else if (port_sel == `SEL_MOTOR) begin
      next_rd_data = rmw ? motor_port_latch : motor_pin; // see RQ12
    end else if (port_sel == `SEL_SERIAL) begin
      next_rd_data = rmw ? serial_port_latch : serial_pin; // see RQ12
    end else if (port_sel == `SEL_ANALOG) begin
      // rmw still reads the pins here, so all eight latches get the pin image
      next_rd_data = analog_in_gated; // see RQ20
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (rd_req && state_s1) begin
      rd_data <= next_rd_data; // see RQ2
    end
  end

  // ****************************************
  // latch and control writes
  // ****************************************
  wire wr_hit = wr_req & state_s2; // see RQ3

  // writes to unmapped selects are dropped without trace: the three-bit
  // port has no direction or open drain select, and only the motor and
  // serial ports have an open drain select; back to back writes are fine

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      six_bit_port_direction <= `SIX_DIR_RST; // see RQ5
      six_bit_port_latch     <= `SIX_LATCH_RST;
      three_bit_port_latch   <= `THREE_LATCH_RST; // see RQ6
      motor_port_direction   <= `OCT_DIR_RST; // see RQ10
      motor_port_latch       <= `OCT_LATCH_RST;
      motor_port_open_drain  <= `OCT_OD_RST; // see RQ11
      serial_port_direction  <= `OCT_DIR_RST; // see RQ14
      serial_port_latch      <= `OCT_LATCH_RST;
      serial_port_open_drain <= `OCT_OD_RST;
      analog_port_direction  <= `OCT_DIR_RST; // see RQ15
      analog_port_latch      <= `OCT_LATCH_RST;
    end else if (wr_hit) begin
      if (port_sel == `SEL_SIX) begin
        if (reg_sel == `REG_LATCH) begin
          six_bit_port_latch <= wr_data[`SIX_W-1:0];
        end else if (reg_sel == `REG_DIR) begin
          six_bit_port_direction <= wr_data[`SIX_W-1:0];
        end
      end else if (port_sel == `SEL_THREE) begin
        if (reg_sel == `REG_LATCH) begin
          three_bit_port_latch <= wr_data[`THREE_W-1:0];
        end
      end else if (port_sel == `SEL_MOTOR) begin
        if (reg_sel == `REG_LATCH) begin
          motor_port_latch <= wr_data;
        end else if (reg_sel == `REG_DIR) begin
          motor_port_direction <= wr_data;
        end else if (reg_sel == `REG_OD) begin
          motor_port_open_drain <= wr_data;
        end
      end else if (port_sel == `SEL_SERIAL) begin
        if (reg_sel == `REG_LATCH) begin
          serial_port_latch <= wr_data;
        end else if (reg_sel == `REG_DIR) begin
          serial_port_direction <= wr_data;
        end else if (reg_sel == `REG_OD) begin
          serial_port_open_drain <= wr_data;
        end
      end else if (port_sel == `SEL_ANALOG) begin
        if (reg_sel == `REG_LATCH) begin
          analog_port_latch <= wr_data; // see RQ20
        end else if (reg_sel == `REG_DIR) begin
          analog_port_direction <= wr_data;
        end
      end
    end
  end

  // ****************************************
  // self-triggered interrupt on the three-bit port
  // ****************************************
  // edge taken from the driven level so a bit the port drives low
  // fires its interrupt latch even with no external activity
  wire [`THREE_W-1:0] three_driven = three_bit_port_latch | ~three_bit_port_oe;
  // the pulse is registered and appears one clock after the latch changes;
  // leaving stop also counts as a fall where the latch is zero and stop floated the pin

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      three_out_prev   <= `THREE_LATCH_RST;
      ext_int_self_set <= {`THREE_W{1'b0}};
    end else begin
      three_out_prev   <= three_driven;
      ext_int_self_set <= three_out_prev & ~three_driven; // see RQ9
    end
  end

endmodule // multi_port_io_block

/* bench/pin_board.sv */
`timescale 1ns/1ps
// ****
// board side of one port
// ****
module pin_board #(
  parameter W = 8
) (
  // pad side of the block
  input  wire [W-1:0] oe,
  input  wire [W-1:0] out,
  // level the board applies to undriven pins
  input  wire [W-1:0] ext,
  // level seen at the pad
  output wire [W-1:0] pin
);
  // the board always drives, so a released pin never floats to x
  assign pin = (oe & out) | (~oe & ext);
endmodule // pin_board

/* bench/multi_port_io_block_props.sv */
`timescale 1ns/1ps
module io_block_checker (
  // clock, reset and cpu side
  input wire       clk,
  input wire       resetn,
  input wire       state_s1,
  input wire       state_s2,
  input wire       rd_req,
  input wire       wr_req,
  input wire       rmw,
  input wire [2:0] port_sel,
  input wire [1:0] reg_sel,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire       stop_mode,
  input wire       stop_output_hold,
  input wire       analog_input_disable,
  // pads
  input wire [5:0] six_bit_port_out,
  input wire [5:0] six_bit_port_oe,
  input wire [2:0] three_bit_port_out,
  input wire [2:0] three_bit_port_oe,
  input wire [2:0] ext_int_self_set,
  input wire [7:0] motor_port_out,
  input wire [7:0] motor_port_oe,
  input wire [7:0] analog_port_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire wr_go = wr_req && state_s2;
  wire rd_go = rd_req && state_s1;
  wire six_dir_wr = wr_go && port_sel == 3'h0 && reg_sel == 2'h1;
  wire motor_wr   = wr_go && port_sel == 3'h2;

  chk_write_lands:
    assert property (wr_go && port_sel == 3'h2 && reg_sel == 2'h0 |=> motor_port_out == $past(wr_data))
    else $error("motor latch missed write");
  chk_latch_holds:
    assert property (!wr_go |=> $stable(six_bit_port_out) && $stable(motor_port_out))
    else $error("latch moved without write");
  chk_dir_cause:
    assert property ($changed(six_bit_port_oe) |-> $past(six_dir_wr))
    else $error("six oe moved without direction write");
  chk_od_cause:
    assert property ($changed(motor_port_oe) |-> $past(motor_wr))
    else $error("motor oe moved without write");
  chk_rmw_latch:
    assert property (rd_go && rmw && port_sel == 3'h1 && reg_sel == 2'h0
                     |=> rd_data == {5'h00, $past(three_bit_port_out)})
    else $error("three rmw read not latch");
  chk_rd_holds:
    assert property (!rd_go |=> $stable(rd_data))
    else $error("read data moved without read");
  chk_stop_float:
    assert property (stop_mode |-> !three_bit_port_oe[0] && (stop_output_hold || three_bit_port_oe == 3'h0))
    else $error("three pin driven in stop");
  chk_int_pulse:
    assert property ($fell(three_bit_port_out[0]) && three_bit_port_oe[0] |-> ##[0:3] ext_int_self_set[0])
    else $error("no interrupt pulse on driven fall");
  chk_ana_zero:
    assert property (rd_go && port_sel == 3'h4 && reg_sel == 2'h0
                     |=> (rd_data & ~$past(analog_port_out)) == 8'h00)
    else $error("analog bit with latch zero read one");
  chk_ana_off:
    assert property (rd_go && port_sel == 3'h4 && reg_sel == 2'h0 && analog_input_disable
                     |=> rd_data == 8'h00)
    else $error("disabled analog read not zero");
endmodule // io_block_checker

bind multi_port_io_block io_block_checker i_chk (
  .clk(clk), .resetn(resetn), .state_s1(state_s1), .state_s2(state_s2), .rd_req(rd_req),
  .wr_req(wr_req), .rmw(rmw), .port_sel(port_sel), .reg_sel(reg_sel), .wr_data(wr_data),
  .rd_data(rd_data), .stop_mode(stop_mode), .stop_output_hold(stop_output_hold),
  .analog_input_disable(analog_input_disable), .six_bit_port_out(six_bit_port_out),
  .six_bit_port_oe(six_bit_port_oe), .three_bit_port_out(three_bit_port_out),
  .three_bit_port_oe(three_bit_port_oe), .ext_int_self_set(ext_int_self_set),
  .motor_port_out(motor_port_out), .motor_port_oe(motor_port_oe),
  .analog_port_out(analog_port_out)
);

/* bench/multi_port_io_block_tb_top.sv */
`timescale 1ns/1ps
module multi_port_io_block_tb_top;
  logic       clk, resetn, state_s1, state_s2, rd_req, wr_req, rmw;
  logic       stop_mode, stop_output_hold, analog_input_disable;
  logic [2:0] port_sel, p, e3, seen_int;
  logic [1:0] reg_sel;
  logic [7:0] wr_data, em, es, ea, v, m, x, w;
  logic [5:0] e6;
  wire  [7:0] rd_data, motor_port_out, motor_port_oe, serial_port_out, serial_port_oe;
  wire  [7:0] analog_port_out, analog_port_oe, pm, ps, pa;
  wire  [5:0] six_bit_port_out, six_bit_port_oe, p6;
  wire  [2:0] three_bit_port_out, three_bit_port_oe, ext_int_self_set, p3;
  int         err_count, checks, cyc;
  integer     seed = 32'hba379a4d;
  logic [7:0] exp_q[$];

  multi_port_io_block i_dut (
    .clk, .resetn, .state_s1, .state_s2, .rd_req, .wr_req, .rmw, .port_sel, .reg_sel,
    .wr_data, .rd_data, .stop_mode, .stop_output_hold, .analog_input_disable,
    .six_bit_port_in(p6), .six_bit_port_out, .six_bit_port_oe,
    .three_bit_port_in(p3), .three_bit_port_out, .three_bit_port_oe, .ext_int_self_set,
    .motor_port_in(pm), .motor_port_out, .motor_port_oe,
    .serial_port_in(ps), .serial_port_out, .serial_port_oe,
    .analog_port_in(pa), .analog_port_out, .analog_port_oe
  );
  pin_board #(.W(6)) i_b6 (.oe(six_bit_port_oe), .out(six_bit_port_out), .ext(e6), .pin(p6));
  pin_board #(.W(3)) i_b3 (.oe(three_bit_port_oe), .out(three_bit_port_out), .ext(e3), .pin(p3));
  pin_board i_bm (.oe(motor_port_oe), .out(motor_port_out), .ext(em), .pin(pm));
  pin_board i_bs (.oe(serial_port_oe), .out(serial_port_out), .ext(es), .pin(ps));
  pin_board i_ba (.oe(analog_port_oe), .out(analog_port_out), .ext(ea), .pin(pa));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(string nm, logic [79:0] seen, logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one access: request held over one sampling edge, released on it
  task automatic acc(bit wt, bit rm, logic [2:0] ps_, logic [1:0] rs, logic [7:0] d);
    @(posedge clk);
    {wr_req, state_s2, rd_req, state_s1} <= {wt, wt, !wt, !wt};
    {rmw, port_sel, reg_sel, wr_data} <= {rm, ps_, rs, d};
    @(posedge clk);
    {wr_req, state_s2, rd_req, state_s1} <= 4'h0;
  endtask

  task automatic rd(logic [2:0] ps_, bit rm, logic [7:0] e);
    exp_q.push_back(e);
    acc(0, rm, ps_, 2'h0, 8'h00);
  endtask

  function automatic logic [15:0] po(logic [2:0] ps_);
    case (ps_)
      3'h0: po = {2'h0, six_bit_port_oe, 2'h0, six_bit_port_out};
      3'h1: po = {5'h00, three_bit_port_oe, 5'h00, three_bit_port_out};
      3'h2: po = {motor_port_oe, motor_port_out};
      3'h3: po = {serial_port_oe, serial_port_out};
      default: po = {analog_port_oe, analog_port_out};
    endcase
  endfunction

  // ****
  // result watcher and hang limit
  // ****
  always @(posedge clk) begin
    if (resetn && rd_req && state_s1) begin
      @(negedge clk);
      chk("rd_data", rd_data, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    seen_int <= resetn ? (seen_int | ext_int_self_set) : 3'h0;
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {resetn, state_s1, state_s2, rd_req, wr_req, rmw, stop_mode, stop_output_hold} = 8'h00;
    {port_sel, reg_sel, wr_data} = 13'h0000;
    analog_input_disable = 1'b1;
    {e6, e3, em, es} = 25'h0;
    ea = 8'hA5;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("rst_out", {po(0), po(1), po(2), po(3), po(4)}, {16'h0000, 16'h0007, 48'h0});
    chk("rst_int", ext_int_self_set, 3'h0);
    repeat (3) @(posedge clk);
    rd(3'h4, 0, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 3'h0 : 3'(k + 1);
      v = 8'($random(seed));
      m = 8'($random(seed));
      x = 8'($random(seed));
      e6 <= x[5:0];
      em <= x;
      es <= x;
      w = (k == 0) ? 8'h3F : 8'hFF;
      acc(1, 0, p, 2'h0, v);
      acc(1, 0, p, 2'h1, m);
      @(negedge clk);
      chk("dir_out", po(p), {m & w, v & w});
      repeat (3) @(posedge clk);
      rd(p, 0, ((m & v) | (~m & x)) & w);
    end
    $display("test direction done");
    for (int k = 2; k < 4; k++) begin
      v = 8'($random(seed));
      x = 8'($random(seed));
      em <= x;
      es <= x;
      acc(1, 0, 3'(k), 2'h2, 8'hFF);
      acc(1, 0, 3'(k), 2'h1, 8'hFF);
      acc(1, 0, 3'(k), 2'h0, v);
      acc(1, 0, 3'(k), 2'h3, 8'h00);
      @(negedge clk);
      chk("od_out", po(3'(k)), {~v, v});
      repeat (3) @(posedge clk);
      rd(3'(k), 0, v & x);
      rd(3'(k), 1, v);
    end
    acc(1, 0, 3'h2, 2'h2, 8'h00);
    acc(1, 0, 3'h2, 2'h0, 8'hFF);
    @(negedge clk);
    chk("motor_drive", po(3'h2), 16'hFFFF);
    @(posedge clk);
    $display("test open drain done");
    e3 <= 3'h5;
    acc(1, 0, 3'h1, 2'h0, 8'h02);
    repeat (4) @(posedge clk);
    chk("int_seen", seen_int, 3'h5);
    chk("three_out", po(1), 16'h0502);
    rd(3'h1, 0, 8'h00);
    rd(3'h1, 1, 8'h02);
    stop_mode <= 1'b1;
    @(negedge clk);
    chk("stop_oe", three_bit_port_oe, 3'h0);
    @(posedge clk);
    stop_output_hold <= 1'b1;
    @(negedge clk);
    chk("hold_oe", three_bit_port_oe, 3'h4);
    @(posedge clk);
    {stop_mode, stop_output_hold} <= 2'h0;
    $display("test three-bit done");
    v = 8'($random(seed));
    x = 8'($random(seed));
    ea <= x;
    acc(1, 0, 3'h4, 2'h0, v);
    repeat (3) @(posedge clk);
    rd(3'h4, 0, 8'h00);
    analog_input_disable <= 1'b0;
    rd(3'h4, 0, v & x);
    rd(3'h4, 1, v & x);
    analog_input_disable <= 1'b1;
    acc(1, 0, 3'h4, 2'h1, 8'hF0);
    @(negedge clk);
    chk("ana_out", po(4), {8'hF0, v});
    $display("test analog done");
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule // multi_port_io_block_tb_top
